// [hw/dsau_pkg.sv]
package dsau_pkg;
	// Address and data widths
	localparam int EA_W = 16;
	localparam int DATA_W = 16;
	localparam int PROG_W = 24;
	localparam int PAGE_W = 8;
	// Program-view mapping: low EA bits kept, top EA bit selects the window
	localparam int PV_LOW_BITS = 15;
	localparam int PV_SEL_BIT = 15;
	localparam int PROG_MSB = 23;
	// Byte lane select bit of an effective address
	localparam int LANE_BIT = 0;
	// Fixed X/Y boundary and top of implemented RAM (plain defaults)
	localparam logic [15:0] Y_BASE = 16'h1800;
	localparam logic [15:0] Y_LAST = 16'h1FFF;
	localparam logic [15:0] IMPL_LAST = 16'h27FF;
	// Stall cycles added by a program-view access
	localparam logic [1:0] EXTRA_NONE = 2'h0;
	localparam logic [1:0] EXTRA_SHORT = 2'h1;
	localparam logic [1:0] EXTRA_LONG = 2'h2;
	// Post-modify steps
	localparam logic [15:0] STEP_BYTE = 16'h0001;
	localparam logic [15:0] STEP_WORD = 16'h0002;
	localparam logic [15:0] ZERO_WORD = 16'h0000;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	// Instruction classes that set the program-view penalty
	typedef enum logic [1:0] {OPC_MAC_PREFETCH, OPC_MOVE, OPC_DWORD_MOVE, OPC_OTHER} op_class_t;
	// Pointer post-modify modes
	typedef enum logic [1:0] {AM_NONE, AM_POSTINC, AM_MODULO, AM_BITREV} amode_t;
	// Access sequencer
	typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_HOLD} state_t;
endpackage

// [hw/pointer_update.sv]
`timescale 1ns/1ps
module pointer_update
	import dsau_pkg::*;
(
	// Current pointer and step
	input wire logic [dsau_pkg::EA_W-1:0] ptr,
	input wire logic [dsau_pkg::EA_W-1:0] step,
	// Mode and circular buffer bounds
	input wire dsau_pkg::amode_t mode,
	input wire logic [dsau_pkg::EA_W-1:0] mod_start,
	input wire logic [dsau_pkg::EA_W-1:0] mod_end,
	input wire logic [dsau_pkg::EA_W-1:0] rev_span,
	input wire logic allow_bitrev,
	// Updated pointer
	output logic [dsau_pkg::EA_W-1:0] ptr_next
);
	import dsau_pkg::*;

	logic [EA_W-1:0] ptr_rev; // Pointer bit-reversed
	logic [EA_W-1:0] span_rev; // Span bit-reversed
	logic [EA_W-1:0] sum_rev; // Forward sum of reversed values
	logic [EA_W-1:0] rev_result; // Reverse-carry result

	// Bit reversal, one wire per bit
	for (genvar i = 0; i < EA_W; i++) begin : g_rev
		assign ptr_rev[i] = ptr[EA_W-1-i];
		assign span_rev[i] = rev_span[EA_W-1-i];
		assign rev_result[i] = sum_rev[EA_W-1-i];
	end
	assign sum_rev = ptr_rev + span_rev;

	// Next pointer per mode
	always_comb begin
		unique case (mode)
			AM_NONE: ptr_next = ptr;
			AM_POSTINC: ptr_next = ptr + step;
			// Wrap at the last address of the buffer
			AM_MODULO: ptr_next = (ptr == mod_end) ? mod_start : ptr + step;
			// Reverse carry only on X writes; otherwise plain increment
			AM_BITREV: ptr_next = allow_bitrev ? rev_result : ptr + step;
		endcase
	end
endmodule // pointer_update

// [hw/data_space_access_unit.sv]
`timescale 1ns/1ps
// Summary of operation
// - Top EA bit plus enable redirects reads to program
// - Upper 32 Kbytes map onto selectable page
// - Address: page bits above EA low 15
// - Program address bit 23 forced zero
// - Only low 16 program bits returned
// - Table instructions suspend program-view mapping
// - One extra cycle: MAC prefetch, moves
// - Two extra cycles for other instructions
// - Repeat: edges two extra, middle none
// - Dual reads: X excludes Y region
// - Dual reads: X, Y each from own pointers
// - All writes on X bus only
// - Accumulator write-back reaches whole space
// - Bit-reverse X writes; modulo both spaces
// - Invalid or cross-space reads return zero
// - EAs are 16-bit byte addresses
// - Byte read selects lane onto low byte
// - Y path reads whole words only
// - Byte write strobes only addressed lane
// - Post-increment by one or two
// - Misaligned word traps; writes suppressed
// - Byte load keeps register high byte
// - Unused program bits should decode illegal
module data_space_access_unit
	import dsau_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Access request from the pipeline
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic req_byte,
	input wire logic req_dual,
	input wire logic acc_writeback,
	input wire dsau_pkg::op_class_t op_class,
	input wire logic [dsau_pkg::EA_W-1:0] ea,
	input wire logic [dsau_pkg::DATA_W-1:0] wr_data,
	input wire logic [dsau_pkg::DATA_W-1:0] wreg_old,
	// Dual-read pointers
	input wire logic [dsau_pkg::EA_W-1:0] x_pointer_a,
	input wire logic [dsau_pkg::EA_W-1:0] x_pointer_b,
	input wire logic [dsau_pkg::EA_W-1:0] y_pointer_a,
	input wire logic [dsau_pkg::EA_W-1:0] y_pointer_b,
	input wire logic x_ptr_sel,
	input wire logic y_ptr_sel,
	// Post-modify control
	input wire dsau_pkg::amode_t addr_mode,
	input wire logic [dsau_pkg::EA_W-1:0] mod_start,
	input wire logic [dsau_pkg::EA_W-1:0] mod_end,
	input wire logic [dsau_pkg::EA_W-1:0] rev_span,
	// Core context
	input wire logic program_view_enable,
	input wire logic [dsau_pkg::PAGE_W-1:0] program_view_page,
	input wire logic table_active,
	input wire logic in_repeat,
	input wire logic rpt_first,
	input wire logic rpt_last,
	input wire logic rpt_irq_exit,
	input wire logic rpt_irq_reentry,
	// Memory read data
	input wire logic [dsau_pkg::DATA_W-1:0] x_mem_rdata,
	input wire logic [dsau_pkg::DATA_W-1:0] y_mem_rdata,
	input wire logic [dsau_pkg::PROG_W-1:0] prog_rdata,
	// Memory addresses and strobes
	output logic [dsau_pkg::EA_W-1:0] x_addr_r,
	output logic [dsau_pkg::EA_W-1:0] y_addr_r,
	output logic [dsau_pkg::PROG_W-1:0] prog_addr_r,
	output logic x_rd_en_r,
	output logic y_rd_en_r,
	output logic prog_rd_en_r,
	output logic x_wr_lo_r,
	output logic x_wr_hi_r,
	output logic [dsau_pkg::DATA_W-1:0] x_wr_data_r,
	// Results to the pipeline
	output logic [dsau_pkg::DATA_W-1:0] x_rd_data_r,
	output logic [dsau_pkg::DATA_W-1:0] y_rd_data_r,
	output logic [dsau_pkg::DATA_W-1:0] wreg_data_r,
	output logic [dsau_pkg::EA_W-1:0] x_ptr_next_r,
	output logic [dsau_pkg::EA_W-1:0] y_ptr_next_r,
	output logic done_r,
	output logic stall_r,
	output logic addr_err_r
);
	import dsau_pkg::*;

	state_t state_r; // Sequencer state
	logic [1:0] cnt_r; // Remaining extra cycles
	logic pv_r; // Access goes to program memory
	logic byte_r; // Byte operand
	logic wr_r; // Write access
	logic dual_r; // Dual-operand read
	logic x_zero_r; // X read forced to zero
	logic y_zero_r; // Y read forced to zero
	logic err_r; // Misaligned word access seen
	logic [DATA_W-1:0] wreg_old_r; // Register image for byte merge

	logic take; // Request accepted this cycle
	logic finish; // Last cycle of the access
	logic [EA_W-1:0] xea; // Effective address on X path
	logic [EA_W-1:0] yea; // Effective address on Y path
	logic pv_hit; // Program-view redirect
	logic x_in_y; // X address falls in Y region
	logic y_in_y; // Y address falls in Y region
	logic unimpl; // No memory behind the address
	logic misalign; // Word access at odd address
	logic [1:0] extra_nxt; // Stall cycles for this access
	logic [EA_W-1:0] step; // Post-modify step
	logic [EA_W-1:0] x_next; // X pointer after update
	logic [EA_W-1:0] y_next; // Y pointer after update
	logic [DATA_W-1:0] x_word; // Word seen on the X read path
	logic [7:0] x_lane; // Selected byte

	assign take = (state_r == ST_IDLE) && req_valid;
	assign finish = (state_r != ST_IDLE) && (cnt_r == EXTRA_NONE);

	// Dual reads address X only from X pointers, Y only from Y pointers
	assign xea = (req_dual && !req_write) ? (x_ptr_sel ? x_pointer_b : x_pointer_a) : ea;
	assign yea = y_ptr_sel ? y_pointer_b : y_pointer_a;

	// Redirect reads of the upper half; table instructions suspend it
	assign pv_hit = xea[PV_SEL_BIT] && program_view_enable && !table_active && !req_write;

	assign x_in_y = (xea >= Y_BASE) && (xea <= Y_LAST);
	assign y_in_y = (yea >= Y_BASE) && (yea <= Y_LAST);
	// Full 16-bit byte address space; unbacked addresses read as zero
	assign unimpl = (xea > IMPL_LAST) && !pv_hit;
	// Y path never carries bytes, so only word accesses can misalign
	assign misalign = (!req_byte || req_dual) && (xea[LANE_BIT] || (req_dual && yea[LANE_BIT]));

	// Penalty for a program-view access
	always_comb begin
		extra_nxt = EXTRA_NONE;
		if (pv_hit && in_repeat) begin
			// Loop edges pay twice; steady iterations pay nothing
			if (rpt_first || rpt_last || rpt_irq_exit || rpt_irq_reentry)
				extra_nxt = EXTRA_LONG;
		end else if (pv_hit) begin
			if (op_class == OPC_OTHER)
				extra_nxt = EXTRA_LONG;
			else
				extra_nxt = EXTRA_SHORT;
		end
	end

	// Step scales with operand size; dual prefetches are always words
	assign step = (req_byte && !req_dual) ? STEP_BYTE : STEP_WORD;

	// Byte lane selection shared by data RAM and program view
	assign x_word = x_zero_r ? ZERO_WORD : (pv_r ? prog_rdata[DATA_W-1:0] : x_mem_rdata);
	assign x_lane = x_addr_r[LANE_BIT] ? x_word[15:8] : x_word[7:0];

	// X pointer update: bit-reverse only on writes
	pointer_update u_x_upd (
		.ptr(xea),
		.step(step),
		.mode(addr_mode),
		.mod_start(mod_start),
		.mod_end(mod_end),
		.rev_span(rev_span),
		.allow_bitrev(req_write),
		.ptr_next(x_next)
	);

	// Y pointer update: modulo allowed, never bit-reverse
	pointer_update u_y_upd (
		.ptr(yea),
		.step(STEP_WORD),
		.mode(addr_mode),
		.mod_start(mod_start),
		.mod_end(mod_end),
		.rev_span(rev_span),
		.allow_bitrev(1'b0),
		.ptr_next(y_next)
	);

	// Sequencer: hold the pipeline until the access ends
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
			cnt_r <= EXTRA_NONE;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					if (take) begin
						state_r <= ST_ISSUE;
						cnt_r <= extra_nxt;
					end
				end
				ST_ISSUE, ST_HOLD: begin
					// Program-view penalty cycles count down here before completion
					if (finish)
						state_r <= ST_IDLE;
					else begin
						state_r <= ST_HOLD;
						cnt_r <= cnt_r - 2'h1;
					end
				end
			endcase
		end
	end

	// Stall from acceptance to completion
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			stall_r <= 1'b0;
		else if (take)
			stall_r <= 1'b1;
		else if (finish)
			stall_r <= 1'b0;
	end

	// Capture of the request attributes
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pv_r <= 1'b0;
			byte_r <= 1'b0;
			wr_r <= 1'b0;
			dual_r <= 1'b0;
			x_zero_r <= 1'b0;
			y_zero_r <= 1'b0;
			err_r <= 1'b0;
			wreg_old_r <= ZERO_WORD;
		end else if (take) begin
			pv_r <= pv_hit;
			byte_r <= req_byte && !req_dual;
			wr_r <= req_write;
			dual_r <= req_dual && !req_write;
			// Write-back sees the whole space; dual reads exclude Y from X
			x_zero_r <= !req_write && (unimpl || (req_dual && !acc_writeback && x_in_y));
			y_zero_r <= req_dual && !y_in_y;
			err_r <= misalign;
			wreg_old_r <= wreg_old;
		end
	end

	// Addresses toward the arrays
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			x_addr_r <= ZERO_WORD;
			y_addr_r <= ZERO_WORD;
			prog_addr_r <= '0;
		end else if (take) begin
			x_addr_r <= xea;
			y_addr_r <= yea;
			// Page on top of EA low bits; top program bit forced clear
			prog_addr_r <= {1'b0, program_view_page, xea[PV_LOW_BITS-1:0]};
		end
	end

	// Read enables stand through the whole access
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			x_rd_en_r <= 1'b0;
			y_rd_en_r <= 1'b0;
			prog_rd_en_r <= 1'b0;
		end else if (take) begin
			x_rd_en_r <= !req_write && !pv_hit;
			y_rd_en_r <= req_dual && !req_write;
			prog_rd_en_r <= pv_hit;
		end else if (finish) begin
			x_rd_en_r <= 1'b0;
			y_rd_en_r <= 1'b0;
			prog_rd_en_r <= 1'b0;
		end
	end

	// Write strobes: X bus only, one cycle, lane per byte address
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			x_wr_lo_r <= 1'b0;
			x_wr_hi_r <= 1'b0;
			x_wr_data_r <= ZERO_WORD;
		end else if (take && req_write && !misalign) begin
			// Misaligned writes run to completion with no update
			x_wr_lo_r <= !req_byte || !xea[LANE_BIT];
			x_wr_hi_r <= !req_byte || xea[LANE_BIT];
			// Byte data rides on both lanes; strobe picks one
			x_wr_data_r <= req_byte ? {wr_data[7:0], wr_data[7:0]} : wr_data;
		end else begin
			x_wr_lo_r <= 1'b0;
			x_wr_hi_r <= 1'b0;
		end
	end

	// Updated pointers, registered when the request is taken
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			x_ptr_next_r <= ZERO_WORD;
			y_ptr_next_r <= ZERO_WORD;
		end else if (take) begin
			x_ptr_next_r <= x_next;
			y_ptr_next_r <= y_next;
		end
	end

	// Read data capture at the end of the access
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			x_rd_data_r <= ZERO_WORD;
			y_rd_data_r <= ZERO_WORD;
			wreg_data_r <= ZERO_WORD;
		end else if (finish && !wr_r) begin
			// Upper program bits are dropped; they should hold an illegal opcode
			x_rd_data_r <= byte_r ? {ZERO_BYTE, x_lane} : x_word;
			y_rd_data_r <= (y_zero_r || !dual_r) ? ZERO_WORD : y_mem_rdata;
			// Byte loads leave the register high byte alone
			wreg_data_r <= byte_r ? {wreg_old_r[15:8], x_lane} : x_word;
		end
	end

	// Completion pulse and address error trap
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			done_r <= 1'b0;
			addr_err_r <= 1'b0;
		end else begin
			done_r <= finish;
			addr_err_r <= finish && err_r;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_pv_addr_form: assert property (prog_rd_en_r
		|-> prog_addr_r[PV_LOW_BITS-1:0] == x_addr_r[PV_LOW_BITS-1:0])
		else $error("program address low bits differ from EA");
	a_pv_msb_clear: assert property (prog_rd_en_r |-> !prog_addr_r[PROG_MSB])
		else $error("program-view address reached top half");
	a_table_blocks: assert property (take && table_active |=> !prog_rd_en_r)
		else $error("program view used during table access");
	a_short_stall: assert property (take && pv_hit && !in_repeat && op_class != OPC_OTHER
		|=> !done_r [*2] ##1 done_r)
		else $error("short program-view penalty wrong");
	a_long_stall: assert property (take && pv_hit && !in_repeat && op_class == OPC_OTHER
		|=> !done_r [*3] ##1 done_r)
		else $error("long program-view penalty wrong");
	a_repeat_steady: assert property (take && pv_hit && in_repeat && !rpt_first && !rpt_last
		&& !rpt_irq_exit && !rpt_irq_reentry |=> !done_r ##1 done_r)
		else $error("steady repeat iteration stalled");
	a_y_read_only: assert property ((x_wr_lo_r || x_wr_hi_r) |-> wr_r && !y_rd_en_r)
		else $error("write seen alongside Y path");
	a_zero_invalid: assert property (done_r && $past(x_zero_r) && !$past(wr_r)
		|-> x_rd_data_r == ZERO_WORD)
		else $error("invalid read returned data");
	a_misalign_trap: assert property (take && req_write && misalign
		|=> !x_wr_lo_r && !x_wr_hi_r ##1 addr_err_r)
		else $error("misaligned write not trapped or not suppressed");
	a_byte_lane: assert property (take && req_write && req_byte && xea[LANE_BIT]
		|=> x_wr_hi_r && !x_wr_lo_r)
		else $error("wrong byte lane strobed");
	a_step_size: assert property (take && addr_mode == AM_POSTINC && req_byte && !req_dual
		|=> x_ptr_next_r == $past(xea) + STEP_BYTE)
		else $error("byte post-increment not by one");
endmodule // data_space_access_unit

// [dv/mem_arrays_model.sv]
`timescale 1ns/1ps
// Far-side data and program arrays, read combinationally
module mem_arrays_model
	import dsau_pkg::*;
(
	// Addresses and read enables from the unit
	input wire logic [dsau_pkg::EA_W-1:0] x_addr,
	input wire logic [dsau_pkg::EA_W-1:0] y_addr,
	input wire logic [dsau_pkg::PROG_W-1:0] prog_addr,
	input wire logic x_rd_en,
	input wire logic y_rd_en,
	input wire logic prog_rd_en,
	// Read data back to the unit
	output logic [dsau_pkg::DATA_W-1:0] x_mem_rdata,
	output logic [dsau_pkg::DATA_W-1:0] y_mem_rdata,
	output logic [dsau_pkg::PROG_W-1:0] prog_rdata
);
	// Word contents are a fixed function of the word address; lane bit ignored
	logic [15:0] x_word;
	logic [15:0] y_word;
	logic [23:0] p_word;
	assign x_word = {x_addr[15:1], 1'b0} ^ 16'h5AA5;
	assign y_word = {y_addr[15:1], 1'b0} ^ 16'hC33C;
	// Upper program byte holds an illegal-opcode pattern
	assign p_word = {8'hFF, {prog_addr[15:1], 1'b0} ^ 16'h1234};
	// Released arrays show the inverse, so stale data cannot pass as a hit
	always_comb begin
		x_mem_rdata = x_rd_en ? x_word : ~x_word;
		y_mem_rdata = y_rd_en ? y_word : ~y_word;
		prog_rdata = prog_rd_en ? p_word : ~p_word;
	end
endmodule // mem_arrays_model

// [dv/data_space_access_unit_bench.sv]
`timescale 1ns/1ps
module data_space_access_unit_bench;
	import dsau_pkg::*;
	// Clock, reset and request
	logic core_clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_write = 1'b0, req_byte = 1'b0;
	logic req_dual = 1'b0, acc_writeback = 1'b0, x_ptr_sel = 1'b0, y_ptr_sel = 1'b0;
	op_class_t op_class = OPC_MOVE;
	amode_t addr_mode = AM_NONE;
	logic [15:0] ea = 16'h0000, wr_data = 16'h0000, wreg_old = 16'h0000;
	logic [15:0] x_pointer_a = 16'h0000, x_pointer_b = 16'h0000, y_pointer_a = 16'h0000, y_pointer_b = 16'h0000;
	// Circular and bit-reverse bounds, moved only by the pointer-mode scenario
	logic [15:0] mod_start = 16'h0000, mod_end = 16'hFFFF, rev_span = 16'h0000;
	// Core context
	logic program_view_enable = 1'b0, table_active = 1'b0, in_repeat = 1'b0;
	logic rpt_first = 1'b0, rpt_last = 1'b0, rpt_irq_exit = 1'b0, rpt_irq_reentry = 1'b0;
	logic [7:0] program_view_page = 8'h00;
	// Array side
	logic [15:0] x_mem_rdata, y_mem_rdata, x_addr_r, y_addr_r, x_wr_data_r;
	logic [23:0] prog_rdata, prog_addr_r;
	logic x_rd_en_r, y_rd_en_r, prog_rd_en_r, x_wr_lo_r, x_wr_hi_r;
	// Results
	logic [15:0] x_rd_data_r, y_rd_data_r, wreg_data_r, x_ptr_next_r, y_ptr_next_r;
	logic done_r, stall_r, addr_err_r;
	// Captured per access: cycle 1 view, then completion view
	int lat;
	logic lo, hi, pen, yen, err, xen;
	logic [15:0] xa, ya, wdat, xn, yn, xd, yd, wd;
	logic [23:0] pa;
	int failures = 0;
	int cmp_count = 0;

	data_space_access_unit u_dut (.*);
	mem_arrays_model u_mem (.x_addr(x_addr_r), .y_addr(y_addr_r), .prog_addr(prog_addr_r), .x_rd_en(x_rd_en_r),
		.y_rd_en(y_rd_en_r), .prog_rd_en(prog_rd_en_r), .x_mem_rdata(x_mem_rdata), .y_mem_rdata(y_mem_rdata),
		.prog_rdata(prog_rdata));

	// Free-running core clock
	initial begin
		forever #5 core_clk = ~core_clk;
	end

	// Expected array words, kept apart from the model's own logic
	function automatic logic [15:0] xdat(input logic [15:0] a);
		return {a[15:1], 1'b0} ^ 16'h5AA5;
	endfunction
	function automatic logic [15:0] ydat(input logic [15:0] a);
		return {a[15:1], 1'b0} ^ 16'hC33C;
	endfunction

	// Verdict and end of run
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Value compare
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Cycle-count compare
	task automatic chk_lat(input int got, input int exp);
		cmp_count++;
		if (got != exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One access: present at a falling edge, taken at the next rising edge
	task automatic run(input logic wr, input logic byt, input logic [15:0] a);
		@(negedge core_clk);
		req_write = wr;
		req_byte = byt;
		ea = a;
		req_valid = 1'b1;
		@(negedge core_clk);
		req_valid = 1'b0;
		lat = 1;
		// Strobes stand in cycle 1 only; addresses are sampled there too
		lo = x_wr_lo_r;
		hi = x_wr_hi_r;
		wdat = x_wr_data_r;
		xa = x_addr_r;
		pa = prog_addr_r;
		pen = prog_rd_en_r;
		yen = y_rd_en_r;
		xen = x_rd_en_r;
		ya = y_addr_r;
		xn = x_ptr_next_r;
		yn = y_ptr_next_r;
		chk(stall_r, 1'b1);
		// Bounded wait for completion
		while (done_r !== 1'b1 && lat < 12) begin
			@(negedge core_clk);
			lat++;
		end
		if (lat >= 12) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, lat, 2);
			complete_run();
		end
		xd = x_rd_data_r;
		yd = y_rd_data_r;
		wd = wreg_data_r;
		err = addr_err_r;
		chk(stall_r, 1'b0);
	endtask

	// Plain reads: X, Y region seen unified, unimplemented, upper half unmapped
	task automatic t_plain();
		logic [15:0] adr [4] = '{16'h0A10, 16'h1810, 16'h3000, 16'h8010};
		for (int i = 0; i < 4; i++) begin
			run(1'b0, 1'b0, adr[i]);
			chk_lat(lat, 2);
			chk(xa, adr[i]);
			chk(pen, 1'b0);
			chk(xen, 1'b1);
			chk(xd, (i < 2) ? xdat(adr[i]) : 16'h0000);
		end
		run(1'b0, 1'b0, 16'h0A11);
		chk(err, 1'b1);
		chk(xd, xdat(16'h0A10));
		$display("t_plain done");
	endtask

	// Byte reads on both lanes with register merge and pointer step
	task automatic t_byte();
		logic [15:0] w;
		logic [7:0] b;
		wreg_old = 16'hBEEF;
		addr_mode = AM_POSTINC;
		x_pointer_a = 16'h0A40;
		w = xdat(16'h0A10);
		for (int i = 0; i < 2; i++) begin
			run(1'b0, 1'b1, 16'h0A10 + 16'(i));
			b = i ? w[15:8] : w[7:0];
			chk(xd, {8'h00, b});
			chk(wd, {8'hBE, b});
			chk(err, 1'b0);
			// Single accesses step the effective address itself
			chk(xn, 16'h0A11 + 16'(i));
		end
		addr_mode = AM_NONE;
		$display("t_byte done");
	endtask

	// Writes: word, byte lane, misaligned, accumulator into Y region
	task automatic t_write();
		wr_data = 16'h1357;
		run(1'b1, 1'b0, 16'h0A20);
		chk({lo, hi}, 2'h3);
		chk(wdat, 16'h1357);
		chk(yen, 1'b0);
		wr_data = 16'h00C4;
		run(1'b1, 1'b1, 16'h0A21);
		chk({lo, hi}, 2'h1);
		chk(wdat, 16'hC4C4);
		run(1'b1, 1'b0, 16'h0A23);
		chk({lo, hi}, 2'h0);
		chk(err, 1'b1);
		acc_writeback = 1'b1;
		run(1'b1, 1'b0, 16'h1804);
		chk({lo, hi}, 2'h3);
		chk(xa, 16'h1804);
		acc_writeback = 1'b0;
		$display("t_write done");
	endtask

	// Program view: address build, penalties, repeat edges, table suspend
	task automatic t_pv();
		program_view_enable = 1'b1;
		program_view_page = 8'hFF;
		for (int c = 0; c < 4; c++) begin
			op_class = op_class_t'(c);
			run(1'b0, 1'b0, 16'h8246);
			chk(pa, {1'b0, 8'hFF, 15'h0246});
			chk(pen, 1'b1);
			chk(xen, 1'b0);
			chk_lat(lat, (c == 3) ? 4 : 3);
			chk(xd, 16'h9072);
		end
		in_repeat = 1'b1;
		program_view_page = 8'h35;
		for (int f = 0; f < 5; f++) begin
			{rpt_first, rpt_last, rpt_irq_exit, rpt_irq_reentry} = f ? (4'h8 >> (f - 1)) : 4'h0;
			run(1'b0, 1'b0, 16'hFFFE);
			chk_lat(lat, f ? 4 : 2);
			chk(pa, {1'b0, 8'h35, 15'h7FFE});
		end
		{rpt_first, rpt_last, rpt_irq_exit, rpt_irq_reentry} = 4'h0;
		in_repeat = 1'b0;
		op_class = OPC_MOVE;
		run(1'b0, 1'b1, 16'h8247);
		chk(xd, 16'h0090);
		table_active = 1'b1;
		run(1'b0, 1'b0, 16'h8246);
		chk(pen, 1'b0);
		chk_lat(lat, 2);
		chk(xd, 16'h0000);
		table_active = 1'b0;
		program_view_enable = 1'b0;
		$display("t_pv done");
	endtask

	// Dual operand reads: split spaces, pointer steps, cross-space zero
	task automatic t_dual();
		req_dual = 1'b1;
		addr_mode = AM_POSTINC;
		y_ptr_sel = 1'b1;
		x_pointer_a = 16'h0800;
		y_pointer_b = 16'h1802;
		run(1'b0, 1'b0, 16'h0000);
		chk({xa, yen}, {16'h0800, 1'b1});
		chk(ya, 16'h1802);
		chk(xd, xdat(16'h0800));
		chk(yd, ydat(16'h1802));
		chk(xn, 16'h0802);
		chk(yn, 16'h1804);
		x_ptr_sel = 1'b1;
		y_ptr_sel = 1'b0;
		x_pointer_b = 16'h1810;
		y_pointer_a = 16'h0400;
		run(1'b0, 1'b0, 16'h0000);
		chk(xd, 16'h0000);
		chk(yd, 16'h0000);
		req_dual = 1'b0;
		addr_mode = AM_NONE;
		$display("t_dual done");
	endtask

	// Pointer modes: circular wrap on X and Y, bit-reverse on X writes only
	task automatic t_modes();
		mod_start = 16'h0300;
		mod_end = 16'h0400;
		addr_mode = AM_MODULO;
		run(1'b0, 1'b0, 16'h0400);
		chk(xn, 16'h0300);
		req_dual = 1'b1;
		x_ptr_sel = 1'b0;
		y_ptr_sel = 1'b0;
		x_pointer_a = 16'h0A00;
		y_pointer_a = 16'h0400;
		run(1'b0, 1'b0, 16'h0000);
		chk(yn, 16'h0300);
		chk(xn, 16'h0A02);
		req_dual = 1'b0;
		// Reverse-carry add of span 0x0010 onto 0x0A10 lands on 0x0A08
		addr_mode = AM_BITREV;
		rev_span = 16'h0010;
		run(1'b1, 1'b0, 16'h0A10);
		chk(xn, 16'h0A08);
		run(1'b0, 1'b0, 16'h0A10);
		chk(xn, 16'h0A12);
		addr_mode = AM_NONE;
		$display("t_modes done");
	endtask

	// Reset for two cycles, then the scenarios
	initial begin
		repeat (2) @(posedge core_clk);
		@(negedge core_clk);
		rst_n = 1'b1;
		t_plain();
		t_byte();
		t_write();
		t_pv();
		t_dual();
		t_modes();
		complete_run();
	end
endmodule // data_space_access_unit_bench
